// *** rtl/dram_rank_config_decode.sv ***
// Purpose: Memory configuration registers and host address to rank decode
// Assumes: AXI4-Lite slave at 40 MHz aclk, synchronous active-low reset
// Notes: Decode answers one cycle after req_valid; bounds in 64 MB units
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module dram_rank_config_decode (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    output logic resp_valid,
    output logic resp_hit,
    output logic resp_channel,
    output logic [1:0] resp_rank,
    output logic [13:0] resp_row,
    output logic [2:0] resp_bank,
    output logic [9:0] resp_col,
    output logic [2:0] resp_page_code,
    output logic [dram_cfg_pkg::FREQ_W-1:0] mem_freq_sel,
    output logic [31:0] timing_a,
    output logic [31:0] timing_b,
    output logic [31:0] refresh_ctl_a,
    output logic [31:0] refresh_ctl_b,
    output logic interleave_mode
);
    import dram_cfg_pkg::*;

    // ********************************************************************
    // Helper functions
    // ********************************************************************

    // Byte-lane merge honouring write strobes
    function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // Page field of one rank, two fields to a byte
    function automatic logic [2:0] page_field(input logic [15:0] regv,
                                              input logic [1:0] rank);
        logic [15:0] sh;
        sh = regv >> (rank * PAGE_STRIDE);
        return sh[PAGE_FIELD_W-1:0];
    endfunction : page_field

    // Split a rank-local byte offset into {row, bank, column}
    function automatic logic [26:0] split_addr(input logic [31:0] loc,
                                               input logic [2:0] geo);
        logic [3:0] ncol;
        logic [3:0] nbank;
        logic [3:0] nrow;
        logic [31:0] beat;
        logic [31:0] col;
        logic [31:0] bank;
        logic [31:0] row;
        ncol = (geo == GEO_256_X16) ? 4'd9 : 4'd10;
        nbank = (geo == GEO_1G_X16 || geo == GEO_1G_X8) ? 4'd3 : 4'd2;
        nrow = (geo == GEO_512_X8 || geo == GEO_1G_X8) ? 4'd14 : 4'd13;
        beat = loc >> BEAT_SHIFT;
        col = beat & ((32'h0000_0001 << ncol) - 32'h0000_0001);
        beat = beat >> ncol;
        bank = beat & ((32'h0000_0001 << nbank) - 32'h0000_0001);
        beat = beat >> nbank;
        row = beat & ((32'h0000_0001 << nrow) - 32'h0000_0001);
        return {row[13:0], bank[2:0], col[9:0]};
    endfunction : split_addr

    // ********************************************************************
    // Register storage
    // ********************************************************************
    bound_set_t bound_a_reg;
    bound_set_t bound_b_reg;
    logic [PAGE_REG_W-1:0] page_a_reg;
    logic [PAGE_REG_W-1:0] page_b_reg;
    logic [FREQ_W-1:0] freq_reg;
    logic [31:0] timing_a_reg;
    logic [31:0] timing_b_reg;
    logic [31:0] refresh_a_reg;
    logic [31:0] refresh_b_reg;
    logic mode_il_reg;
    logic [3:0] status_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ********************************************************************
    // AXI4-Lite write path
    // ********************************************************************

    // Address and data are taken together; no write is taken while a response waits
    logic wr_take;
    logic [7:0] waddr;
    logic wr_bound_a;
    logic wr_bound_b;
    logic wr_hit;
    logic [1:0] widx;
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign waddr = s_axi_awaddr;
    assign widx = waddr[3:2];
    assign wr_bound_a = (waddr[7:4] == OFS_BOUND_A[7:4]) && (waddr[1:0] == 2'b00);
    assign wr_bound_b = (waddr[7:4] == OFS_BOUND_B[7:4]) && (waddr[1:0] == 2'b00);
    assign wr_hit = wr_bound_a || wr_bound_b || waddr == OFS_PAGE_A || waddr == OFS_PAGE_B
        || waddr == OFS_FREQ || waddr == OFS_TIMING_A || waddr == OFS_TIMING_B
        || waddr == OFS_REFRESH_A || waddr == OFS_REFRESH_B || waddr == OFS_MODE
        || waddr == OFS_STATUS;

    // Merged values for the two bound targets, read-only status ignores writes
    logic [31:0] wm_bound_a;
    logic [31:0] wm_bound_b;
    assign wm_bound_a = merge_strb({24'h00_0000, bound_a_reg[widx]}, s_axi_wdata, s_axi_wstrb);
    assign wm_bound_b = merge_strb({24'h00_0000, bound_b_reg[widx]}, s_axi_wdata, s_axi_wstrb);

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bound_a_reg <= {NUM_RANKS{RST_BOUND}};
            bound_b_reg <= {NUM_RANKS{RST_BOUND}};
            page_a_reg <= RST_PAGE;
            page_b_reg <= RST_PAGE;
            freq_reg <= RST_FREQ;
            timing_a_reg <= RST_TIMING;
            timing_b_reg <= RST_TIMING;
            refresh_a_reg <= RST_REFRESH;
            refresh_b_reg <= RST_REFRESH;
            mode_il_reg <= RST_MODE_IL;
        end else if (wr_take) begin
            if (wr_bound_a) begin
                bound_a_reg[widx] <= wm_bound_a[BOUND_W-1:0];
            end else if (wr_bound_b) begin
                bound_b_reg[widx] <= wm_bound_b[BOUND_W-1:0];
            end else if (waddr == OFS_PAGE_A) begin
                page_a_reg <= 16'(merge_strb({16'h0000, page_a_reg}, s_axi_wdata,
                                             s_axi_wstrb));
            end else if (waddr == OFS_PAGE_B) begin
                page_b_reg <= 16'(merge_strb({16'h0000, page_b_reg}, s_axi_wdata, s_axi_wstrb));
            end else if (waddr == OFS_FREQ) begin
                freq_reg <= 3'(merge_strb({29'h0000_0000, freq_reg}, s_axi_wdata, s_axi_wstrb));
            end else if (waddr == OFS_TIMING_A) begin
                timing_a_reg <= merge_strb(timing_a_reg, s_axi_wdata, s_axi_wstrb);
            end else if (waddr == OFS_TIMING_B) begin
                timing_b_reg <= merge_strb(timing_b_reg, s_axi_wdata, s_axi_wstrb);
            end else if (waddr == OFS_REFRESH_A) begin
                refresh_a_reg <= merge_strb(refresh_a_reg, s_axi_wdata, s_axi_wstrb);
            end else if (waddr == OFS_REFRESH_B) begin
                refresh_b_reg <= merge_strb(refresh_b_reg, s_axi_wdata, s_axi_wstrb);
            end else if (waddr == OFS_MODE && s_axi_wstrb[0]) begin
                mode_il_reg <= s_axi_wdata[MODE_IL_BIT];
            end
        end
    end

    // Write response, held until bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_take) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ********************************************************************
    // AXI4-Lite read path
    // ********************************************************************
    logic rd_take;
    logic [7:0] raddr;
    logic [1:0] ridx;
    logic rd_bound_a;
    logic rd_bound_b;
    logic rd_hit;
    logic [31:0] rd_mux;
    assign rd_take = s_axi_arvalid && !rvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign raddr = s_axi_araddr;
    assign ridx = raddr[3:2];
    assign rd_bound_a = (raddr[7:4] == OFS_BOUND_A[7:4]) && (raddr[1:0] == 2'b00);
    assign rd_bound_b = (raddr[7:4] == OFS_BOUND_B[7:4]) && (raddr[1:0] == 2'b00);
    assign rd_hit = rd_bound_a || rd_bound_b || raddr == OFS_PAGE_A || raddr == OFS_PAGE_B
        || raddr == OFS_FREQ || raddr == OFS_TIMING_A || raddr == OFS_TIMING_B
        || raddr == OFS_REFRESH_A || raddr == OFS_REFRESH_B || raddr == OFS_MODE
        || raddr == OFS_STATUS;

    // Read data select; unmapped words return zero with an error response
    assign rd_mux = rd_bound_a ? {24'h00_0000, bound_a_reg[ridx]}
        : rd_bound_b ? {24'h00_0000, bound_b_reg[ridx]}
        : (raddr == OFS_PAGE_A) ? {16'h0000, page_a_reg}
        : (raddr == OFS_PAGE_B) ? {16'h0000, page_b_reg}
        : (raddr == OFS_FREQ) ? {29'h0000_0000, freq_reg}
        : (raddr == OFS_TIMING_A) ? timing_a_reg
        : (raddr == OFS_TIMING_B) ? timing_b_reg
        : (raddr == OFS_REFRESH_A) ? refresh_a_reg
        : (raddr == OFS_REFRESH_B) ? refresh_b_reg
        : (raddr == OFS_MODE) ? {31'h0000_0000, mode_il_reg}
        : (raddr == OFS_STATUS) ? {28'h000_0000, status_reg}
        : 32'h0000_0000;

    // Read response, held stable until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ********************************************************************
    // Rank decode
    // ********************************************************************

    // A 32-bit address cannot reach past 4 GB, so larger bounds simply never miss
    logic [7:0] addr_units;
    logic a_hit;
    logic b_hit;
    logic [1:0] a_rank;
    logic [1:0] b_rank;
    logic [7:0] a_base;
    logic [7:0] b_base;
    assign addr_units = {2'b00, req_addr[31:UNIT_SHIFT]};

    // Channel A starts at zero
    rank_lookup u_lookup_a (
        .addr_units(addr_units),
        .bounds(bound_a_reg),
        .floor_units(8'h00),
        .hit(a_hit),
        .rank(a_rank),
        .base_units(a_base)
    );

    // Channel B continues above the top of channel A
    rank_lookup u_lookup_b (
        .addr_units(addr_units),
        .bounds(bound_b_reg),
        .floor_units(bound_a_reg[NUM_RANKS-1]),
        .hit(b_hit),
        .rank(b_rank),
        .base_units(b_base)
    );

    // Interleaved reads only channel A bounds, each naming a rank pair
    logic dec_hit;
    logic dec_ch;
    logic [1:0] dec_rank;
    logic [7:0] dec_base;
    logic [31:0] dec_off;
    logic [31:0] dec_local;
    logic [2:0] dec_geo;
    logic [26:0] dec_split;
    assign dec_hit = mode_il_reg ? a_hit : (a_hit || b_hit);
    assign dec_ch = mode_il_reg ? req_addr[LINE_BIT] : !a_hit;
    assign dec_rank = (mode_il_reg || a_hit) ? a_rank : b_rank;
    assign dec_base = (mode_il_reg || a_hit) ? a_base : b_base;
    assign dec_off = req_addr - {dec_base[5:0], 26'h000_0000};
    // Drop the channel bit so each channel sees a dense half of the pair
    assign dec_local = mode_il_reg ? {1'b0, dec_off[31:LINE_BIT+1], dec_off[LINE_BIT-1:0]}
                                   : dec_off;
    assign dec_geo = (mode_il_reg || !dec_ch) ? page_field(page_a_reg, dec_rank)
                                              : page_field(page_b_reg, dec_rank);
    assign dec_split = split_addr(dec_local, dec_geo);

    // Registered decode answer plus sticky status of the last lookup
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resp_valid <= 1'b0;
            resp_hit <= 1'b0;
            resp_channel <= 1'b0;
            resp_rank <= 2'b00;
            resp_row <= 14'h0000;
            resp_bank <= 3'h0;
            resp_col <= 10'h000;
            resp_page_code <= 3'h0;
            status_reg <= 4'h0;
        end else begin
            resp_valid <= req_valid;
            if (req_valid) begin
                resp_hit <= dec_hit;
                resp_channel <= dec_ch;
                resp_rank <= dec_rank;
                resp_row <= dec_split[26:13];
                resp_bank <= dec_split[12:10];
                resp_col <= dec_split[9:0];
                resp_page_code <= dec_geo;
                status_reg <= {dec_hit, dec_ch, dec_rank};
            end
        end
    end

    // Control outputs; one frequency for every DIMM
    assign mem_freq_sel = freq_reg;
    assign timing_a = timing_a_reg;
    assign timing_b = timing_b_reg;
    assign refresh_ctl_a = refresh_a_reg;
    assign refresh_ctl_b = refresh_b_reg;
    assign interleave_mode = mode_il_reg;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_resp_latency;
        req_valid |=> resp_valid;
    endproperty
    a_resp_latency: assert property (p_resp_latency) else $error("decode answer late");

    property p_no_spurious;
        !req_valid |=> !resp_valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");

    property p_il_channel;
        (req_valid && mode_il_reg) |=> (resp_channel == $past(req_addr[LINE_BIT]));
    endproperty
    a_il_channel: assert property (p_il_channel) else $error("wrong interleave channel");

    property p_fill_a_first;
        (req_valid && !mode_il_reg && addr_units < bound_a_reg[NUM_RANKS-1])
            |=> (resp_hit && !resp_channel);
    endproperty
    a_fill_a_first: assert property (p_fill_a_first) else $error("channel A not first");

    property p_top_miss;
        (req_valid && addr_units >= bound_a_reg[NUM_RANKS-1]
            && (mode_il_reg || addr_units >= bound_b_reg[NUM_RANKS-1])) |=> !resp_hit;
    endproperty
    a_top_miss: assert property (p_top_miss) else $error("hit above top bound");

    property p_rank0;
        (req_valid && addr_units < bound_a_reg[0]) |=> (resp_hit && resp_rank == 2'b00);
    endproperty
    a_rank0: assert property (p_rank0) else $error("lowest rank not chosen");

    property p_bound_write;
        (wr_take && waddr == OFS_BOUND_A && s_axi_wstrb[0])
            |=> (bound_a_reg[0] == $past(s_axi_wdata[7:0]) && s_axi_bvalid);
    endproperty
    a_bound_write: assert property (p_bound_write) else $error("bound write lost");

    property p_rdata_hold;
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");

    property p_col_256x16;
        (req_valid && dec_geo == GEO_256_X16) |=> (resp_col[9] == 1'b0);
    endproperty
    a_col_256x16: assert property (p_col_256x16) else $error("column too wide");

endmodule : dram_rank_config_decode
`default_nettype wire

// *** inc/dram_cfg_pkg.sv ***
// Purpose: Shared constants and types for the rank configuration and decode block
// Assumes: 32-bit AXI4-Lite data, 8-bit register byte addresses
// Notes: Rank bounds count in 64 MB units; geometry codes set row, bank and column widths
package dram_cfg_pkg;

    // ********************************************************************
    // Register map (byte addresses)
    // ********************************************************************
    localparam logic [7:0] OFS_BOUND_A = 8'h00;
    localparam logic [7:0] OFS_BOUND_B = 8'h10;
    localparam logic [7:0] OFS_PAGE_A = 8'h20;
    localparam logic [7:0] OFS_PAGE_B = 8'h24;
    localparam logic [7:0] OFS_FREQ = 8'h28;
    localparam logic [7:0] OFS_TIMING_A = 8'h2C;
    localparam logic [7:0] OFS_TIMING_B = 8'h30;
    localparam logic [7:0] OFS_REFRESH_A = 8'h34;
    localparam logic [7:0] OFS_REFRESH_B = 8'h38;
    localparam logic [7:0] OFS_MODE = 8'h3C;
    localparam logic [7:0] OFS_STATUS = 8'h40;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] RST_BOUND = 8'h00;
    localparam logic [15:0] RST_PAGE = 16'h0000;
    localparam logic [2:0] RST_FREQ = 3'h0;
    localparam logic [31:0] RST_TIMING = 32'h0000_0000;
    localparam logic [31:0] RST_REFRESH = 32'h0000_0000;
    localparam logic RST_MODE_IL = 1'b0;

    // ********************************************************************
    // Field layouts
    // ********************************************************************
    localparam int NUM_RANKS = 4;
    localparam int BOUND_W = 8;
    localparam int UNIT_SHIFT = 26;
    localparam int PAGE_FIELD_W = 3;
    localparam int PAGE_STRIDE = 4;
    localparam int PAGE_REG_W = 16;
    localparam int FREQ_W = 3;
    localparam int MODE_IL_BIT = 0;
    localparam int LINE_BIT = 6;
    localparam int BEAT_SHIFT = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ********************************************************************
    // Device geometry codes held in each rank page field
    // ********************************************************************
    localparam logic [2:0] GEO_256_X16 = 3'h0;
    localparam logic [2:0] GEO_256_X8 = 3'h1;
    localparam logic [2:0] GEO_512_X16 = 3'h2;
    localparam logic [2:0] GEO_512_X8 = 3'h3;
    localparam logic [2:0] GEO_1G_X16 = 3'h4;
    localparam logic [2:0] GEO_1G_X8 = 3'h5;

    typedef logic [NUM_RANKS-1:0][BOUND_W-1:0] bound_set_t;

endpackage : dram_cfg_pkg

// *** rtl/rank_lookup.sv ***
// Purpose: Picks the lowest rank whose upper bound lies above an address
// Assumes: Bounds are cumulative and non-decreasing, in 64 MB units
// Notes: Purely combinational; floor_units sets where this channel starts
`timescale 1ns/1ps
`default_nettype none
module rank_lookup (
    input wire logic [7:0] addr_units,
    input wire dram_cfg_pkg::bound_set_t bounds,
    input wire logic [7:0] floor_units,
    output logic hit,
    output logic [1:0] rank,
    output logic [7:0] base_units
);
    import dram_cfg_pkg::*;

    // Scan from the top so the lowest matching rank wins
    always_comb begin
        hit = 1'b0;
        rank = 2'b00;
        base_units = floor_units;
        for (int i = NUM_RANKS - 1; i >= 0; i--) begin
            if (addr_units >= floor_units && addr_units < bounds[i]) begin
                hit = 1'b1;
                rank = i[1:0];
                base_units = (i == 0) ? floor_units : bounds[(i == 0) ? 0 : i - 1];
            end
        end
    end

endmodule : rank_lookup
`default_nettype wire

// *** verification/dimm_model.sv ***
// Purpose: Far-side model of the DIMMs fed by the controller
// Assumes: All ranks share the one memory clock rate
// Notes: Passive; shows the rate code that the DIMMs were given
`timescale 1ns/1ps
`default_nettype none
module dimm_model (
    input wire logic aclk,
    input wire logic [dram_cfg_pkg::FREQ_W-1:0] freq_sel,
    output var logic [dram_cfg_pkg::FREQ_W-1:0] run_freq
);
    import dram_cfg_pkg::*;

    // Every rank takes the single shared rate; no per-DIMM override exists
    always_ff @(posedge aclk) begin
        run_freq <= freq_sel;
    end
endmodule : dimm_model
`default_nettype wire

// *** verification/test_dram_rank_config_decode.sv ***
// Purpose: Register access and rank decode checks for the config block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: Bounds in 64 MB units; timeout cuts a hang short
`timescale 1ns/1ps
`default_nettype none
module test_dram_rank_config_decode;
    import dram_cfg_pkg::*;
    // Response readies stay high, so every answer is taken at the edge it is seen
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, req_valid = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, req_addr = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_rank;
    logic [31:0] s_axi_rdata, timing_a, timing_b, refresh_ctl_a, refresh_ctl_b;
    logic resp_valid, resp_hit, resp_channel, interleave_mode;
    logic [13:0] resp_row;
    logic [2:0] resp_bank, resp_page_code, run_freq;
    logic [9:0] resp_col;
    logic [FREQ_W-1:0] mem_freq_sel;
    int failures = 0, cmp_count = 0, cyc = 0;
    dram_rank_config_decode dram_rank_config_decode_i (.*);
    dimm_model dimm_model_i (.aclk(aclk), .freq_sel(mem_freq_sel), .run_freq(run_freq));
    initial forever #12.5 aclk = ~aclk;
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    // Address and data offered together, held until both readies
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd
    // Decode answer is due exactly one cycle after the request strobe
    // Mask keeps only the fields the rules define; a miss leaves the rest open
    task automatic dec(input logic [31:0] a, input logic [19:0] e,
                       input logic [19:0] m = 20'hF_FFFF);
        req_addr <= a;
        req_valid <= 1;
        @(posedge aclk);
        req_valid <= 0;
        @(posedge aclk);
        chk("resp_valid", {31'h0, resp_valid}, 32'h0000_0001);
        chk("decode", {12'h0, {resp_hit, resp_channel, resp_rank, resp_page_code, resp_bank,
            resp_col} & m}, {12'h0, e & m});
    endtask : dec
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_FREQ, 32'h0000_0000, RESP_OKAY);
        rd(OFS_MODE, 32'h0000_0000, RESP_OKAY);
        // Asymmetric: A ranks end at 512, 1024, 1280 MB; B continues to 2560 MB
        wr(8'h00, 32'h0000_0008, RESP_OKAY);
        wr(8'h04, 32'h0000_0010, RESP_OKAY);
        wr(8'h08, 32'h0000_0014, RESP_OKAY);
        wr(8'h0C, 32'h0000_0014, RESP_OKAY);
        wr(8'h10, 32'h0000_001C, RESP_OKAY);
        wr(8'h14, 32'h0000_0024, RESP_OKAY);
        wr(8'h18, 32'h0000_0028, RESP_OKAY);
        wr(8'h1C, 32'h0000_0028, RESP_OKAY);
        rd(8'h14, 32'h0000_0024, RESP_OKAY);
        // Both sides of each DIMM carry one geometry; rank 2 of A is 256Mb x16
        wr(OFS_PAGE_A, 32'hFFFF_0055, RESP_OKAY);
        rd(OFS_PAGE_A, 32'h0000_0055, RESP_OKAY);
        wr(OFS_PAGE_B, 32'h0000_0033, RESP_OKAY);
        wr(OFS_FREQ, 32'h0000_0005, RESP_OKAY);
        wr(OFS_TIMING_A, 32'h1234_5678, RESP_OKAY);
        wr(OFS_TIMING_B, 32'h9ABC_DEF0, RESP_OKAY);
        wr(OFS_REFRESH_A, 32'h0000_0A5A, RESP_OKAY);
        wr(OFS_REFRESH_B, 32'h0000_05A5, RESP_OKAY);
        chk("timing_a", timing_a, 32'h1234_5678);
        chk("refresh_a", refresh_ctl_a, 32'h0000_0A5A);
        chk("timing_b", timing_b, 32'h9ABC_DEF0);
        chk("refresh_b", refresh_ctl_b, 32'h0000_05A5);
        chk("run_freq", {29'h0, run_freq}, 32'h0000_0005);
        rd(OFS_TIMING_A, 32'h1234_5678, RESP_OKAY);
        rd(OFS_REFRESH_A, 32'h0000_0A5A, RESP_OKAY);
        wr(8'h44, 32'h0000_0001, RESP_SLVERR);
        rd(8'h44, 32'h0000_0000, RESP_SLVERR);
        wr(OFS_STATUS, 32'h0000_000F, RESP_OKAY);
        dec(32'h4000_1238, {1'h1, 1'h0, 2'h2, 3'h0, 3'h1, 10'h047});
        dec(32'h2000_2008, {1'h1, 1'h0, 2'h1, 3'h5, 3'h1, 10'h001});
        dec(32'h0010_0000, {1'h1, 1'h0, 2'h0, 3'h5, 3'h0, 10'h000});
        chk("row", {18'h0, resp_row}, 32'h0000_0010);
        dec(32'h5000_0000, {1'h1, 1'h1, 2'h0, 3'h3, 3'h0, 10'h000});
        dec(32'hA000_0000, 20'h0_0000, 20'h8_0000);
        // Status keeps {hit, channel, rank}; the miss leaves hit clear
        rd(OFS_STATUS, 32'h0000_0004, RESP_OKAY);
        // Interleaved: address bit 6 picks the channel, A bounds cover the pair
        wr(OFS_MODE, 32'h0000_0001, RESP_OKAY);
        chk("il_mode", {31'h0, interleave_mode}, 32'h0000_0001);
        dec(32'h0000_0040, {1'h1, 1'h1, 2'h0, 3'h5, 3'h0, 10'h000});
        dec(32'h0000_0080, {1'h1, 1'h0, 2'h0, 3'h5, 3'h0, 10'h008});
        dec(32'h2000_0040, {1'h1, 1'h1, 2'h1, 3'h5, 3'h0, 10'h000});
        report_and_stop();
    end
endmodule : test_dram_rank_config_decode
`default_nettype wire
